// ### design/arfm_defines.vh
// register offsets, field positions, reset values and encodings of the result formatter
`ifndef ARFM_DEFINES_VH
`define ARFM_DEFINES_VH
`define ARFM_OFF_SELECT 12'h000
`define ARFM_OFF_CTRL2 12'h004
`define ARFM_OFF_RES_LOW 12'h008
`define ARFM_OFF_RES_HIGH 12'h00C
`define ARFM_OFF_STATUS 12'h010
`define ARFM_OFF_MASK 12'h014
`define ARFM_SELECT_RESET 8'h00
`define ARFM_CTRL2_RESET 8'h00
`define ARFM_MASK_RESET 8'h00
`define ARFM_SEL_LADJ_BIT 5
`define ARFM_CTRL2_BIN_BIT 7
`define ARFM_CTRL2_IPR_BIT 5
`define ARFM_STAT_DONE_BIT 0
`define ARFM_STAT_SAT_BIT 1
`define ARFM_CHAN_TEMP 4'hF
`define ARFM_CODE_MAX 10'h3FF
`define ARFM_CODE_ZERO 10'h000
`define ARFM_BIP_MAX 11'sh1FF
`define ARFM_BIP_MIN -11'sh200
`define ARFM_GAIN_HIGH 5'h14
`define ARFM_GAIN_UNITY 5'h01
`endif

// ### design/arfm_chan_decode.v
// decodes the channel select field into input kind and gain
`timescale 1ns/100ps
`default_nettype none
`include "arfm_defines.vh"
module arfm_chan_decode (
  input wire [3:0] channel_select,
  output reg differential,
  output reg high_gain,
  output reg temp_sensor_enable
);
  // codes 4..11 are differential pairs, odd codes among them take gain twenty
  always @* begin
    differential = (channel_select >= 4'h4) && (channel_select <= 4'hB);
    high_gain = differential && channel_select[0];
    temp_sensor_enable = (channel_select == `ARFM_CHAN_TEMP);
  end
endmodule
`default_nettype wire

// ### design/arfm_formatter.v
// turns a raw signed difference or level into the 10-bit result code
`timescale 1ns/100ps
`default_nettype none
`include "arfm_defines.vh"
module arfm_formatter (
  input wire [10:0] raw_value,
  input wire differential,
  input wire bipolar,
  input wire high_gain,
  output reg [9:0] code,
  output reg saturated
);
  reg signed [16:0] scaled;
  reg signed [16:0] halved;
  // raw_value is the signed difference in unipolar lsb units (x1024/vref)
  always @* begin
    scaled = $signed(raw_value) * $signed({12'h000, high_gain ? `ARFM_GAIN_HIGH :
      `ARFM_GAIN_UNITY});
    halved = scaled >>> 1;
    saturated = 1'b0;
    code = `ARFM_CODE_ZERO;
    if (!differential) begin
      // single-ended: level counts straight, negative levels clip to zero
      if (raw_value[10]) begin
        code = `ARFM_CODE_ZERO;
        saturated = 1'b1;
      end else if (raw_value[9:0] > `ARFM_CODE_MAX) begin
        code = `ARFM_CODE_MAX;
      end else begin
        code = raw_value[9:0];
      end
    end else if (!bipolar) begin
      // unipolar: negative differences clamp at zero
      if (scaled < 0) begin
        code = `ARFM_CODE_ZERO;
        saturated = 1'b1;
      end else if (scaled > $signed({7'h00, `ARFM_CODE_MAX})) begin
        code = `ARFM_CODE_MAX;
        saturated = 1'b1;
      end else begin
        code = scaled[9:0];
      end
    end else begin
      // bipolar: half scale, two's complement, bit 9 is the sign
      if (halved > $signed({{6{1'b0}}, `ARFM_BIP_MAX})) begin
        code = 10'h1FF;
        saturated = 1'b1;
      end else if (halved < $signed({{6{1'b1}}, `ARFM_BIP_MIN})) begin
        code = 10'h200;
        saturated = 1'b1;
      end else begin
        code = halved[9:0];
      end
    end
  end
endmodule
`default_nettype wire

// ### design/arfm_result_mux.v
// result formatting and channel/reference selection block with an ahb-lite slave
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "arfm_defines.vh"
module arfm_result_mux (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire conv_start,
  input wire conv_done,
  input wire [10:0] conv_raw,
  output reg conv_busy,
  output reg [3:0] active_channel,
  output reg [2:0] active_reference,
  output reg active_high_gain,
  output reg active_differential,
  output reg temp_sensor_enable,
  output reg polarity_reverse,
  output wire irq
);
  // slave state machine, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [11:0] addr_q;
  reg write_q;
  reg [7:0] channel_reference_select;
  reg [7:0] control_status_second;
  reg [9:0] result_code;
  reg [1:0] status;
  reg [1:0] mask;
  wire conversion_done_flag;
  wire [1:0] event_set;
  wire [1:0] next_status;
  wire status_read;
  wire sel_load;
  wire [3:0] channel_select;
  wire [2:0] reference_select;
  wire left_adjust;
  wire bipolar_select;
  wire dec_diff;
  wire dec_gain;
  wire dec_temp;
  wire [9:0] fmt_code;
  wire fmt_sat;
  wire take;
  wire do_write;
  wire do_read;
  reg [7:0] result_low_byte;
  reg [7:0] result_high_byte;

  assign channel_select = channel_reference_select[3:0];
  assign reference_select = {channel_reference_select[4], channel_reference_select[7:6]};
  assign left_adjust = channel_reference_select[`ARFM_SEL_LADJ_BIT];
  assign bipolar_select = control_status_second[`ARFM_CTRL2_BIN_BIT];

  // decode of the live selection for the converter's next conversion
  arfm_chan_decode u_decode (
    .channel_select(channel_select),
    .differential(dec_diff),
    .high_gain(dec_gain),
    .temp_sensor_enable(dec_temp)
  );

  // formatting uses the gain and input kind latched for the running conversion, and the live bipolar bit
  arfm_formatter u_format (
    .raw_value(conv_raw),
    .differential(active_differential),
    .bipolar(bipolar_select),
    .high_gain(active_high_gain),
    .code(fmt_code),
    .saturated(fmt_sat)
  );

  // bus handshake: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel && hready && htrans[1];

  always @* begin
    case (state)
      ST_IDLE: next_state = take ? ST_DATA : ST_IDLE;
      ST_DATA: next_state = take ? ST_DATA : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // address phase capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      addr_q <= 12'h000;
      write_q <= 1'b0;
    end else begin
      state <= next_state;
      if (take) begin
        addr_q <= haddr;
        write_q <= hwrite;
      end
    end
  end

  assign do_write = (state == ST_DATA) && write_q;
  assign do_read = (state == ST_DATA) && !write_q;

  // a status read in its data phase clears the sticky bits
  assign status_read = do_read && (addr_q == `ARFM_OFF_STATUS);

  // software-written configuration registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_reference_select <= `ARFM_SELECT_RESET;
      control_status_second <= `ARFM_CTRL2_RESET;
      mask <= 2'h0;
    end else if (do_write) begin
      case (addr_q)
        `ARFM_OFF_SELECT: channel_reference_select <= hwdata[7:0];
        `ARFM_OFF_CTRL2: control_status_second <= hwdata[7:0];
        `ARFM_OFF_MASK: mask <= hwdata[1:0];
        default: mask <= mask;
      endcase
    end
  end

  // the selection tracks software while idle and reloads on the completing edge
  assign sel_load = !conv_busy || conv_done;

  // converter-facing selection, frozen while a conversion runs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_busy <= 1'b0;
      active_channel <= 4'h0;
      active_reference <= 3'h0;
      active_high_gain <= 1'b0;
      active_differential <= 1'b0;
      temp_sensor_enable <= 1'b0;
      polarity_reverse <= 1'b0;
    end else begin
      if (conv_done) begin
        conv_busy <= 1'b0;
      end else if (conv_start) begin
        conv_busy <= 1'b1;
      end
      if (sel_load) begin
        active_channel <= channel_select;
        active_reference <= reference_select;
        active_high_gain <= dec_gain;
        active_differential <= dec_diff;
        temp_sensor_enable <= dec_temp;
        polarity_reverse <= control_status_second[`ARFM_CTRL2_IPR_BIT];
      end
    end
  end

  // result lands on the same edge that sets the done flag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_code <= 10'h000;
    end else if (conv_done) begin
      result_code <= fmt_code;
    end
  end

  // events that set the sticky bits: completion, and completion with a clipped code
  assign event_set[`ARFM_STAT_DONE_BIT] = conv_done;
  assign event_set[`ARFM_STAT_SAT_BIT] = conv_done && fmt_sat;

  // per-bit sticky update, set wins over the clearing read
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sticky
      assign next_status[gi] = event_set[gi] || (status[gi] && !status_read);
    end
  endgenerate

  // sticky event bits
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= 2'h0;
    end else begin
      status <= next_status;
    end
  end

  // done flag is the sticky completion bit, set on the result's edge
  assign conversion_done_flag = status[`ARFM_STAT_DONE_BIT];

  assign irq = |(status & mask);

  // justification follows the live left adjust bit
  always @* begin
    if (left_adjust) begin
      result_high_byte = result_code[9:2];
      result_low_byte = {result_code[1:0], 6'h00};
    end else begin
      result_high_byte = {6'h00, result_code[9:8]};
      result_low_byte = result_code[7:0];
    end
  end

  // read data, driven from the registers during the read data phase only
  always @* begin
    hrdata = 32'h00000000;
    if (do_read) begin
      case (addr_q)
        `ARFM_OFF_SELECT: hrdata = {24'h000000, channel_reference_select};
        `ARFM_OFF_CTRL2: hrdata = {24'h000000, control_status_second};
        `ARFM_OFF_RES_LOW: hrdata = {24'h000000, result_low_byte};
        `ARFM_OFF_RES_HIGH: hrdata = {24'h000000, result_high_byte};
        `ARFM_OFF_STATUS: hrdata = {29'h0000000, conv_busy, status[`ARFM_STAT_SAT_BIT],
          conversion_done_flag};
        `ARFM_OFF_MASK: hrdata = {30'h0000000, mask};
        default: hrdata = 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### dv/arfm_result_mux_sva.sv
// port-level assertions for the result formatter
`timescale 1ns/100ps
`default_nettype none
module arfm_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic conv_busy,
  input wire logic [3:0] active_channel,
  input wire logic [2:0] active_reference,
  input wire logic active_high_gain,
  input wire logic active_differential,
  input wire logic temp_sensor_enable,
  input wire logic irq
);
  logic rd_ph;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // marks the data phase of an accepted read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rd_ph <= 1'b0;
    else if (hready) rd_ph <= hsel & htrans[1] & !hwrite;
  end
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  a_rdata_idle: assert property (!rd_ph |-> hrdata == 32'h0) else $error("read data outside phase");
  a_busy_start: assert property (conv_start && !conv_done |=> conv_busy)
    else $error("busy not raised");
  a_busy_done: assert property (conv_done |=> !conv_busy) else $error("busy not dropped");
  a_chan_frozen: assert property (conv_busy && $past(conv_busy) |-> $stable(active_channel))
    else $error("channel moved mid conversion");
  a_gain_frozen: assert property (conv_busy && $past(conv_busy) |-> $stable(active_high_gain))
    else $error("gain moved mid conversion");
  a_ref_frozen: assert property (conv_busy ##1 conv_busy |-> $stable(active_reference))
    else $error("reference moved mid conversion");
  a_temp_route: assert property ((active_channel == 4'hF) == temp_sensor_enable)
    else $error("temperature sensor enable wrong");
  a_temp_single: assert property (temp_sensor_enable |-> !active_differential)
    else $error("temperature channel not single ended");
  a_gain_code: assert property (active_high_gain |-> active_differential && active_channel[0])
    else $error("high gain on wrong code");
  a_diff_code: assert property (active_differential == (active_channel inside {[4:11]}))
    else $error("differential decode wrong");
  c_done: cover property (conv_done);
  c_irq: cover property ($rose(irq));
  c_temp: cover property (temp_sensor_enable);
  c_busy_write: cover property (conv_busy && hsel && htrans[1] && hwrite);
endmodule
bind arfm_result_mux arfm_sva chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .conv_start(conv_start), .conv_done(conv_done), .conv_busy(conv_busy),
  .active_channel(active_channel), .active_reference(active_reference),
  .active_high_gain(active_high_gain), .active_differential(active_differential),
  .temp_sensor_enable(temp_sensor_enable), .irq(irq));
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the result formatter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, conv_start = 1'b0, conv_done = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, r;
  logic [10:0] conv_raw = 11'h000;
  wire [31:0] hrdata;
  wire [3:0] active_channel;
  wire [2:0] active_reference;
  wire hreadyout, hresp, conv_busy, active_high_gain, active_differential;
  wire temp_sensor_enable, polarity_reverse, irq, hready;
  int mismatches = 0, cmp_count = 0;
  // select, second control, raw level, expected {high, low} bytes
  logic [42:0] rows [10] = '{{8'h00, 8'h00, 11'h155, 16'h0155}, {8'h20, 8'h00, 11'h3FF, 16'hFFC0},
    {8'h06, 8'h00, 11'h7FB, 16'h0000}, {8'h07, 8'h00, 11'h03C, 16'h03FF},
    {8'h07, 8'h00, 11'h00A, 16'h00C8}, {8'h06, 8'h80, 11'h79C, 16'h03CE},
    {8'h06, 8'h80, 11'h0C8, 16'h0064}, {8'h07, 8'h80, 11'h738, 16'h0200},
    {8'h26, 8'h80, 11'h79C, 16'hF380}, {8'h8F, 8'h00, 11'h12C, 16'h012C}};
  assign hready = hreadyout;
  arfm_result_mux uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start),
    .conv_done(conv_done), .conv_raw(conv_raw), .conv_busy(conv_busy),
    .active_channel(active_channel), .active_reference(active_reference),
    .active_high_gain(active_high_gain), .active_differential(active_differential),
    .temp_sensor_enable(temp_sensor_enable), .polarity_reverse(polarity_reverse), .irq(irq));
  // 100 ns clock
  always #50 hclk = ~hclk;
  // one single-word transfer, address phase then data phase
  task bus(input [11:0] a, input w, input [31:0] d, output [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  // one conversion from start pulse to completion pulse
  task conv(input [10:0] raw);
    conv_start <= 1'b1;
    @(posedge hclk);
    conv_start <= 1'b0;
    repeat (3) @(posedge hclk);
    conv_done <= 1'b1;
    conv_raw <= raw;
    @(posedge hclk);
    conv_done <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  task chk(input [31:0] g, input [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #1000000;
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(12'h000, 1'b0, 32'h0, r);
    chk(r, 32'h00);
    bus(12'h004, 1'b0, 32'h0, r);
    chk(r, 32'h00);
    bus(12'h020, 1'b0, 32'h0, r);
    chk(r, 32'h00);
    // table of formats, gains and justifications
    foreach (rows[i]) begin
      bus(12'h000, 1'b1, {24'h0, rows[i][42:35]}, r);
      bus(12'h004, 1'b1, {24'h0, rows[i][34:27]}, r);
      conv(rows[i][26:16]);
      chk(irq, 32'h0);
      bus(12'h008, 1'b0, 32'h0, r);
      chk(r, {24'h0, rows[i][7:0]});
      bus(12'h00C, 1'b0, 32'h0, r);
      chk(r, {24'h0, rows[i][15:8]});
      bus(12'h010, 1'b0, 32'h0, r);
      chk(r & 32'h1, 32'h1);
    end
    chk(temp_sensor_enable, 32'h1);
    chk(active_differential, 32'h0);
    chk(active_reference, 32'h2);
    // channel written mid conversion waits for completion
    conv_start <= 1'b1;
    @(posedge hclk);
    conv_start <= 1'b0;
    bus(12'h000, 1'b1, 32'h06, r);
    chk(active_channel, 32'hF);
    conv_done <= 1'b1;
    conv_raw <= 11'h155;
    @(posedge hclk);
    conv_done <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(active_channel, 32'h6);
    bus(12'h010, 1'b0, 32'h0, r);
    chk(r, 32'h1);
    // left adjust reshapes the held result at once
    bus(12'h000, 1'b1, 32'h26, r);
    bus(12'h00C, 1'b0, 32'h0, r);
    chk(r, 32'h55);
    // a negative unipolar difference clips to zero and flags saturation
    conv(11'h7FB);
    bus(12'h010, 1'b0, 32'h0, r);
    chk(r, 32'h3);
    bus(12'h00C, 1'b0, 32'h0, r);
    chk(r, 32'h00);
    // unmasked done raises the interrupt, a status read clears it
    bus(12'h014, 1'b1, 32'h1, r);
    @(posedge hclk);
    chk(irq, 32'h0);
    conv(11'h155);
    chk(irq, 32'h1);
    bus(12'h010, 1'b0, 32'h0, r);
    chk(r, 32'h1);
    @(posedge hclk);
    chk(irq, 32'h0);
    // mid-run reset brings registers and converter outputs back to zero
    bus(12'h004, 1'b1, 32'hA0, r);
    conv(11'h155);
    chk(irq, 32'h1);
    chk(polarity_reverse, 32'h1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(irq, 32'h0);
    chk(polarity_reverse, 32'h0);
    chk(active_channel, 32'h0);
    bus(12'h000, 1'b0, 32'h0, r);
    chk(r, 32'h00);
    bus(12'h004, 1'b0, 32'h0, r);
    chk(r, 32'h00);
    bus(12'h010, 1'b0, 32'h0, r);
    chk(r, 32'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
